// ### crac_top.sv
// Card reader attribute and power configuration bank with AXI4-Lite access
//
// Summary of operation
// - Attribute 0 bit 4 selects configured inquiry strings over descriptors.
// - Attribute 0 bit 6 sets first slot write-protect switch polarity.
// - Attribute 0 bit 7 enables the extended configuration range.
// - Attribute 1 bit 4 makes the activity indicator active low.
// - Attribute 1 bit 5 makes indicator show insertion as well as access.
// - Attribute 1 bit 7 sets second slot write-protect switch polarity.
// - Attribute 2 bit 0 attaches on card insert, detaches on removal.
// - Attribute 2 bit 2 selects custom power configuration over default.
// - Power configuration bytes are ignored while that enable is clear.
// - The power configuration used is the nibble at bits 11:8 of two stored bytes.
// - Nibble bit 3 picks internal versus external power switch.
// - With internal switch, nibble bits 2:0 set the current limit.
// - Codes: 0000 off, 0001 external, 1000 int 100 mA, 1010 int 200 mA.
// - Internal switch defaults to 200 mA, 100 mA is the alternative.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module crac_top
	import crac_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [ADDR_W-1:0] s_awaddr,
	input wire logic [2:0] s_awprot,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	// AXI4-Lite write response
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_araddr,
	input wire logic [2:0] s_arprot,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Settings store read port
	output logic store_rd,
	output logic [7:0] store_addr,
	input wire logic [7:0] store_data,
	// Card slot inputs
	input wire logic [1:0] write_protect_switch_in,
	input wire logic card_inserted,
	input wire logic media_access,
	// Configured behaviour
	output logic [1:0] write_protect_out,
	output logic activity_led_out,
	output logic inquiry_custom_out,
	output logic ext_cfg_enable_out,
	output logic card_attach_out,
	output crac_pwr_type card_power_out,
	output logic cfg_loaded_out
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	crac_cfg_type cfg_r, cfg_nxt;
	crac_ld_type ld_r, ld_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic store_rd_nxt;
	logic [7:0] store_addr_nxt;
	logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
	logic [9:0] aw_idx_r, aw_idx_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic do_wr, run;
	logic [9:0] ar_idx;
	logic [31:0] rd_word;
	logic rd_hit, wr_hit;
	logic [1:0] wp_lvl;
	logic led_src, led_lvl;
	logic [3:0] pwr_nib;
	crac_pwr_type pwr_dec;
	logic [1:0] wp_nxt;
	logic led_nxt, inq_nxt, ext_nxt, attach_nxt;
	crac_pwr_type pwr_out_nxt;

	function automatic logic [7:0] upd(input logic [7:0] old,
		input logic [7:0] val, input logic en, input logic [7:0] mask);
		upd = (en ? val : old) & mask;
	endfunction

	assign run = (ld_r == LD_RUN);
	assign s_awready = run && !aw_held_r && !bvalid_r;
	assign s_wready = run && !w_held_r && !bvalid_r;
	assign s_arready = !rvalid_r;
	assign s_bvalid = bvalid_r;
	assign s_bresp = bresp_r;
	assign s_rvalid = rvalid_r;
	assign s_rdata = rdata_r;
	assign s_rresp = rresp_r;

	// ----------------------------------------------------------------
	// Settings load sequence and register contents
	// ----------------------------------------------------------------
	always_comb
	begin
		cfg_nxt = cfg_r;
		ld_nxt = ld_r;
		idx_nxt = idx_r;
		case (ld_r)
			LD_IDLE:
			begin
				ld_nxt = LD_REQ;
				idx_nxt = 3'h0;
			end
			LD_REQ: ld_nxt = LD_WAIT;
			LD_WAIT:
			begin
				// Reserved bits masked so they always read zero
				case (idx_r)
					3'h0: cfg_nxt.maxpwr = store_data;
					3'h1: cfg_nxt.att0 = store_data & ATT0_MASK;
					3'h2: cfg_nxt.att1 = store_data & ATT1_MASK;
					3'h3: cfg_nxt.att2 = store_data & ATT2_MASK;
					3'h4: cfg_nxt.att3 = store_data & ATT3_MASK;
					3'h5: cfg_nxt.pwr[7:0] = store_data;
					3'h6: cfg_nxt.pwr[15:8] = store_data;
					default: cfg_nxt = cfg_r;
				endcase
				if (idx_r == LOAD_LAST)
					ld_nxt = LD_RUN;
				else
				begin
					idx_nxt = idx_r + 3'h1;
					ld_nxt = LD_REQ;
				end
			end
			LD_RUN:
			begin
				if (do_wr)
				begin
					case (aw_idx_r)
						IDX_MAXPWR: cfg_nxt.maxpwr = upd(cfg_r.maxpwr,
							wdata_r[7:0], wstrb_r[0], 8'hff);
						IDX_ATT0: cfg_nxt.att0 = upd(cfg_r.att0,
							wdata_r[7:0], wstrb_r[0], ATT0_MASK);
						IDX_ATT1: cfg_nxt.att1 = upd(cfg_r.att1,
							wdata_r[7:0], wstrb_r[0], ATT1_MASK);
						IDX_ATT2: cfg_nxt.att2 = upd(cfg_r.att2,
							wdata_r[7:0], wstrb_r[0], ATT2_MASK);
						IDX_ATT3: cfg_nxt.att3 = upd(cfg_r.att3,
							wdata_r[7:0], wstrb_r[0], ATT3_MASK);
						IDX_PWR:
						begin
							cfg_nxt.pwr[7:0] = upd(cfg_r.pwr[7:0],
								wdata_r[7:0], wstrb_r[0], 8'hff);
							cfg_nxt.pwr[15:8] = upd(cfg_r.pwr[15:8],
								wdata_r[15:8], wstrb_r[1], 8'hff);
						end
						IDX_CTRL:
						begin
							// Reload restarts the sequence; run-gated outputs drop meanwhile, write_protect_out keeps following the switches
							if (wstrb_r[0] && wdata_r[CTRL_RELOAD])
							begin
								ld_nxt = LD_REQ;
								idx_nxt = 3'h0;
							end
						end
						default: cfg_nxt = cfg_r;
					endcase
				end
			end
			default: ld_nxt = LD_IDLE;
		endcase
		store_rd_nxt = (ld_nxt == LD_REQ);
		store_addr_nxt = NV_FIRST + {5'h00, idx_nxt};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_r <= '{pwr: PWR_RST, att3: ATT3_RST, att2: ATT2_RST,
				att1: ATT1_RST, att0: ATT0_RST, maxpwr: MAXPWR_RST};
			ld_r <= LD_IDLE;
			idx_r <= 3'h0;
			store_rd <= 1'b0;
			store_addr <= NV_FIRST;
		end
		else
		begin
			cfg_r <= cfg_nxt;
			ld_r <= ld_nxt;
			idx_r <= idx_nxt;
			store_rd <= store_rd_nxt;
			store_addr <= store_addr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	assign ar_idx = s_araddr[ADDR_W-1:2];

	always_comb
	begin
		rd_hit = 1'b1;
		rd_word = 32'h0;
		case (ar_idx)
			IDX_MAXPWR: rd_word[7:0] = cfg_r.maxpwr;
			IDX_ATT0: rd_word[7:0] = cfg_r.att0;
			IDX_ATT1: rd_word[7:0] = cfg_r.att1;
			IDX_ATT2: rd_word[7:0] = cfg_r.att2;
			IDX_ATT3: rd_word[7:0] = cfg_r.att3;
			IDX_PWR: rd_word[15:0] = cfg_r.pwr;
			IDX_PWR_RSVD: rd_word = 32'h0;
			IDX_CTRL: rd_word = 32'h0;
			IDX_STAT:
			begin
				rd_word[ST_LOADED] = cfg_loaded_out;
				rd_word[ST_OVERPWR] = (cfg_r.maxpwr > MAXPWR_LIMIT);
				rd_word[ST_EXT] = card_power_out.ext_en;
				rd_word[ST_INT] = card_power_out.int_en;
				rd_word[ST_LIM200] = card_power_out.limit_200;
				rd_word[ST_WP+1:ST_WP] = write_protect_out;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_comb
	begin
		case (aw_idx_r)
			IDX_MAXPWR, IDX_ATT0, IDX_ATT1, IDX_ATT2, IDX_ATT3,
			IDX_PWR, IDX_PWR_RSVD, IDX_CTRL, IDX_STAT: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_comb
	begin
		aw_held_nxt = aw_held_r;
		aw_idx_nxt = aw_idx_r;
		w_held_nxt = w_held_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		do_wr = 1'b0;
		if (s_awvalid && s_awready)
		begin
			aw_held_nxt = 1'b1;
			aw_idx_nxt = s_awaddr[ADDR_W-1:2];
		end
		if (s_wvalid && s_wready)
		begin
			w_held_nxt = 1'b1;
			wdata_nxt = s_wdata;
			wstrb_nxt = s_wstrb;
		end
		// Both halves present: commit and answer in one step
		if (aw_held_r && w_held_r && !bvalid_r)
		begin
			do_wr = 1'b1;
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bvalid_r && s_bready)
			bvalid_nxt = 1'b0;
		if (s_arvalid && s_arready)
		begin
			rvalid_nxt = 1'b1;
			rdata_nxt = rd_word;
			rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_r && s_rready)
			rvalid_nxt = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			aw_idx_r <= 10'h000;
			w_held_r <= 1'b0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= RESP_OKAY;
		end
		else
		begin
			aw_held_r <= aw_held_nxt;
			aw_idx_r <= aw_idx_nxt;
			w_held_r <= w_held_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Configured behaviour
	// ----------------------------------------------------------------
	crac_polarity u_wp0 (
		.lvl(write_protect_switch_in[0]),
		.invert(!cfg_r.att0[ATT0_WP]),
		.y(wp_lvl[0])
	);
	crac_polarity u_wp1 (
		.lvl(write_protect_switch_in[1]),
		.invert(!cfg_r.att1[ATT1_WP]),
		.y(wp_lvl[1])
	);
	// Insertion shown only when the common mode is chosen
	assign led_src = run && (media_access ||
		(cfg_r.att1[ATT1_LEDINS] && card_inserted));
	crac_polarity u_led (
		.lvl(led_src),
		.invert(cfg_r.att1[ATT1_LEDPOL]),
		.y(led_lvl)
	);
	// Custom bytes are not even looked at unless enabled
	assign pwr_nib = cfg_r.att2[ATT2_PWREN] ?
		cfg_r.pwr[PWR_NIB+:4] : PWR_DEFAULT;
	crac_pwr_decode u_pwr (
		.nibble(pwr_nib),
		.enable(run),
		.pwr(pwr_dec)
	);

	always_comb
	begin
		wp_nxt = wp_lvl;
		led_nxt = led_lvl;
		inq_nxt = run && cfg_r.att0[ATT0_INQ];
		ext_nxt = run && cfg_r.att0[ATT0_EXT];
		attach_nxt = run && (!cfg_r.att2[ATT2_ATTACH] || card_inserted);
		pwr_out_nxt = pwr_dec;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			write_protect_out <= 2'h3;
			activity_led_out <= 1'b0;
			inquiry_custom_out <= 1'b0;
			ext_cfg_enable_out <= 1'b0;
			card_attach_out <= 1'b0;
			card_power_out <= '0;
			cfg_loaded_out <= 1'b0;
		end
		else
		begin
			write_protect_out <= wp_nxt;
			activity_led_out <= led_nxt;
			inquiry_custom_out <= inq_nxt;
			ext_cfg_enable_out <= ext_nxt;
			card_attach_out <= attach_nxt;
			card_power_out <= pwr_out_nxt;
			cfg_loaded_out <= run;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Gated on reset so the attempt at the release edge sees no reset value
	wp_first_a: assert property (aresetn |=> write_protect_out[0] ==
		($past(cfg_r.att0[ATT0_WP]) ? $past(write_protect_switch_in[0])
		: !$past(write_protect_switch_in[0])))
		else $error("first slot protect polarity wrong");
	wp_second_a: assert property (!cfg_r.att1[ATT1_WP]
		&& !write_protect_switch_in[1] |=> write_protect_out[1])
		else $error("second slot low input not protected");
	inq_source_a: assert property (run && cfg_r.att0[ATT0_INQ]
		|=> inquiry_custom_out)
		else $error("inquiry source not selected");
	ext_cfg_a: assert property (!cfg_r.att0[ATT0_EXT] |=>
		!ext_cfg_enable_out)
		else $error("extended range enabled while bit clear");
	led_idle_a: assert property (run && !media_access &&
		!cfg_r.att1[ATT1_LEDINS] |=>
		activity_led_out == $past(cfg_r.att1[ATT1_LEDPOL]))
		else $error("indicator left idle level");
	attach_a: assert property (run && cfg_r.att2[ATT2_ATTACH] &&
		!card_inserted |=> !card_attach_out)
		else $error("attached with no card");
	pwr_ignore_a: assert property (run && !cfg_r.att2[ATT2_PWREN]
		|=> card_power_out.int_en && card_power_out.limit_200
		&& !card_power_out.ext_en)
		else $error("custom power used while disabled");
	pwr_ext_a: assert property (run && cfg_r.att2[ATT2_PWREN] &&
		cfg_r.pwr[PWR_NIB+:4] == PWR_EXT |=> card_power_out.ext_en
		&& !card_power_out.int_en)
		else $error("external switch code misdecoded");
	pwr_int100_a: assert property (run && cfg_r.att2[ATT2_PWREN] &&
		cfg_r.pwr[PWR_NIB+:4] == PWR_INT100 |=> card_power_out.int_en
		&& !card_power_out.limit_200)
		else $error("100 mA code misdecoded");
	load_gate_a: assert property (!run |=> !card_attach_out &&
		card_power_out == '0 && !cfg_loaded_out)
		else $error("outputs enabled before load");
	load_time_a: assert property (ld_r == LD_REQ && idx_r == 3'h0
		|-> ##[14:14] run)
		else $error("load sequence length wrong");
	bresp_a: assert property (aw_held_r && w_held_r && !bvalid_r
		|=> s_bvalid)
		else $error("write not answered");

	load_done_c: cover property (ld_r == LD_WAIT ##1 run);
	custom_pwr_c: cover property (run && cfg_r.att2[ATT2_PWREN]);
	reload_c: cover property (run ##1 ld_r == LD_REQ);
	bad_addr_c: cover property (s_rvalid && s_rresp == RESP_SLVERR);
endmodule
`default_nettype wire

// ### crac_pkg.sv
// Constants, carriers and state encodings for the card reader attribute bank
package crac_pkg;
	// ----------------------------------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [9:0] IDX_MAXPWR = 10'h09b;
	localparam logic [9:0] IDX_ATT0 = 10'h09c;
	localparam logic [9:0] IDX_ATT1 = 10'h09d;
	localparam logic [9:0] IDX_ATT2 = 10'h09e;
	localparam logic [9:0] IDX_ATT3 = 10'h09f;
	localparam logic [9:0] IDX_PWR = 10'h0a0;
	localparam logic [9:0] IDX_PWR_RSVD = 10'h0a2;
	localparam logic [9:0] IDX_CTRL = 10'h0b0;
	localparam logic [9:0] IDX_STAT = 10'h0b1;
	// ----------------------------------------------------------------
	// Settings store load sequence
	// ----------------------------------------------------------------
	localparam logic [7:0] NV_FIRST = 8'h9b;
	localparam logic [2:0] LOAD_LAST = 3'h6;
	// ----------------------------------------------------------------
	// Reset values and writable-bit masks
	// ----------------------------------------------------------------
	localparam logic [7:0] MAXPWR_RST = 8'h00;
	localparam logic [7:0] ATT0_RST = 8'h40;
	localparam logic [7:0] ATT1_RST = 8'h80;
	localparam logic [7:0] ATT2_RST = 8'h00;
	localparam logic [7:0] ATT3_RST = 8'h00;
	localparam logic [15:0] PWR_RST = 16'h0a00;
	localparam logic [7:0] ATT0_MASK = 8'hd0;
	localparam logic [7:0] ATT1_MASK = 8'hb0;
	localparam logic [7:0] ATT2_MASK = 8'h05;
	localparam logic [7:0] ATT3_MASK = 8'h80;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ATT0_INQ = 4;
	localparam int ATT0_WP = 6;
	localparam int ATT0_EXT = 7;
	localparam int ATT1_LEDPOL = 4;
	localparam int ATT1_LEDINS = 5;
	localparam int ATT1_WP = 7;
	localparam int ATT2_ATTACH = 0;
	localparam int ATT2_PWREN = 2;
	localparam int PWR_NIB = 8;
	localparam int PWR_SEL_INT = 3;
	localparam int CTRL_RELOAD = 0;
	localparam int ST_LOADED = 0;
	localparam int ST_OVERPWR = 1;
	localparam int ST_EXT = 2;
	localparam int ST_INT = 3;
	localparam int ST_LIM200 = 4;
	localparam int ST_WP = 5;
	// ----------------------------------------------------------------
	// Power codes and bus answers
	// ----------------------------------------------------------------
	localparam logic [3:0] PWR_OFF = 4'h0;
	localparam logic [3:0] PWR_EXT = 4'h1;
	localparam logic [3:0] PWR_INT100 = 4'h8;
	localparam logic [3:0] PWR_INT200 = 4'ha;
	localparam logic [3:0] PWR_DEFAULT = 4'ha;
	// Request is in 2 mA units, so 100 mA is 50
	localparam logic [7:0] MAXPWR_LIMIT = 8'h32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [15:0] pwr;
		logic [7:0] att3;
		logic [7:0] att2;
		logic [7:0] att1;
		logic [7:0] att0;
		logic [7:0] maxpwr;
	} crac_cfg_type;

	typedef struct packed {
		logic ext_en;
		logic int_en;
		logic limit_200;
	} crac_pwr_type;

	typedef enum logic [1:0] {
		LD_IDLE = 2'h0,
		LD_REQ = 2'h1,
		LD_WAIT = 2'h3,
		LD_RUN = 2'h2
	} crac_ld_type;
endpackage

// ### crac_polarity.sv
// Selectable-polarity level stage for switch inputs and indicator outputs
`timescale 1ns/1ps
`default_nettype none
module crac_polarity
	import crac_pkg::*;
(
	// Level and its inversion select
	input wire logic lvl,
	input wire logic invert,
	// Result
	output logic y
);
	assign y = lvl ^ invert;
endmodule
`default_nettype wire

// ### crac_pwr_decode.sv
// Card power nibble decoder
`timescale 1ns/1ps
`default_nettype none
module crac_pwr_decode
	import crac_pkg::*;
(
	// Active nibble and enable
	input wire logic [3:0] nibble,
	input wire logic enable,
	// Decoded switch controls
	output crac_pwr_type pwr
);
	always_comb
	begin
		pwr = '0;
		if (enable)
		begin
			case (nibble)
				PWR_EXT: pwr.ext_en = 1'b1;
				PWR_INT100: pwr.int_en = 1'b1;
				PWR_INT200:
				begin
					pwr.int_en = 1'b1;
					pwr.limit_200 = 1'b1;
				end
				// Off code and every unlisted code leave power off
				default: pwr = '0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### crac_store_model.sv
// Behavioural settings store answering the attribute bank load reads
`timescale 1ns/1ps
`default_nettype none
module crac_store_model
	import crac_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Read port from the bank
	input wire logic store_rd,
	input wire logic [7:0] store_addr,
	output logic [7:0] store_data,
	// Stored byte image
	input wire crac_cfg_type image
);
	logic [7:0] idx;

	assign idx = store_addr - NV_FIRST;
	initial store_data = 8'h5a;

	// Data is good for one cycle only; then it flips so a late sample shows
	always @(posedge aclk)
	begin
		if (store_rd)
			store_data <= image[idx * 8 +: 8];
		else
			store_data <= ~store_data;
	end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the card reader attribute bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import crac_pkg::*;
;
	logic aclk, aresetn;
	logic [11:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, rd;
	logic [3:0] s_wstrb;
	logic s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp, rsp;
	logic store_rd;
	logic [7:0] store_addr, store_data;
	logic [1:0] write_protect_switch_in, write_protect_out;
	logic card_inserted, media_access, activity_led_out;
	logic inquiry_custom_out, ext_cfg_enable_out, card_attach_out;
	logic cfg_loaded_out;
	crac_pwr_type card_power_out;
	crac_cfg_type image;
	int num_errors, comparisons;
	logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h8, 4'ha, 4'h3};

	crac_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
		.s_awprot(3'h0), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arprot(3'h0),
		.s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
		.s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.store_rd(store_rd), .store_addr(store_addr),
		.store_data(store_data),
		.write_protect_switch_in(write_protect_switch_in),
		.card_inserted(card_inserted), .media_access(media_access),
		.write_protect_out(write_protect_out),
		.activity_led_out(activity_led_out),
		.inquiry_custom_out(inquiry_custom_out),
		.ext_cfg_enable_out(ext_cfg_enable_out),
		.card_attach_out(card_attach_out), .card_power_out(card_power_out),
		.cfg_loaded_out(cfg_loaded_out));

	crac_store_model u_store (.aclk(aclk), .store_rd(store_rd),
		.store_addr(store_addr), .store_data(store_data), .image(image));

	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Readies are sampled mid-cycle, so the handshake edge is known early
	task automatic axi_write(input logic [9:0] ix, input logic [31:0] d,
		output logic [1:0] r);
		logic ah, wh, ad, wd, bh;
		int n;
		ad = 0;
		wd = 0;
		bh = 0;
		n = 0;
		@(posedge aclk);
		s_awaddr <= {ix, 2'b00};
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (!bh && n < 100)
		begin
			@(negedge aclk);
			ah = s_awvalid && s_awready;
			wh = s_wvalid && s_wready;
			bh = ad && wd && s_bvalid;
			r = s_bresp;
			@(posedge aclk);
			if (ah)
			begin
				s_awvalid <= 1'b0;
				ad = 1;
			end
			if (wh)
			begin
				s_wvalid <= 1'b0;
				wd = 1;
			end
			n++;
		end
		s_bready <= 1'b0;
		if (n >= 100)
			num_errors++;
	endtask

	task automatic axi_read(input logic [9:0] ix, output logic [31:0] d,
		output logic [1:0] r);
		logic ah, ad, bh;
		int n;
		ad = 0;
		bh = 0;
		n = 0;
		@(posedge aclk);
		s_araddr <= {ix, 2'b00};
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		while (!bh && n < 100)
		begin
			@(negedge aclk);
			ah = s_arvalid && s_arready;
			bh = ad && s_rvalid;
			d = s_rdata;
			r = s_rresp;
			@(posedge aclk);
			if (ah)
			begin
				s_arvalid <= 1'b0;
				ad = 1;
			end
			n++;
		end
		s_rready <= 1'b0;
		if (n >= 100)
			num_errors++;
	endtask

	task automatic rchk(input string nm, input logic [9:0] ix,
		input logic [31:0] exp, input logic [1:0] er);
		axi_read(ix, rd, rsp);
		chk(nm, rd, exp);
		chk(nm, rsp, er);
	endtask

	task automatic settle;
		repeat (2) @(posedge aclk);
		@(negedge aclk);
	endtask

	task automatic wait_loaded;
		int n;
		n = 0;
		while (cfg_loaded_out !== 1'b1 && n < 40)
		begin
			@(negedge aclk);
			n++;
		end
		chk("load_time", n <= 20, 1);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_load;
		@(negedge aclk);
		chk("loaded_early", cfg_loaded_out, 0);
		chk("wp_early", write_protect_out, 2'b11);
		wait_loaded();
		rchk("maxpwr", IDX_MAXPWR, image.maxpwr, RESP_OKAY);
		rchk("att0", IDX_ATT0, image.att0 & ATT0_MASK, RESP_OKAY);
		rchk("att1", IDX_ATT1, image.att1 & ATT1_MASK, RESP_OKAY);
		rchk("att2", IDX_ATT2, image.att2 & ATT2_MASK, RESP_OKAY);
		rchk("att3", IDX_ATT3, image.att3 & ATT3_MASK, RESP_OKAY);
		rchk("pwr", IDX_PWR, image.pwr, RESP_OKAY);
		// Loaded, internal 100 mA, no over-limit request, both slots writable
		rchk("stat", IDX_STAT, 32'h09, RESP_OKAY);
		chk("inq", inquiry_custom_out, 1);
		chk("ext", ext_cfg_enable_out, 1);
		chk("pwr_out", card_power_out, 3'b010);
	endtask

	function automatic logic [2:0] pexp(input logic [3:0] c);
		case (c)
			4'h1: pexp = 3'b100;
			4'h8: pexp = 3'b010;
			4'ha: pexp = 3'b011;
			default: pexp = 3'b000;
		endcase
	endfunction

	task automatic t_power;
		for (int i = 0; i < 5; i++)
		begin
			axi_write(IDX_PWR, {20'h0, codes[i], 8'h00}, rsp);
			settle();
			chk("pwr_code", card_power_out, pexp(codes[i]));
		end
		axi_write(IDX_ATT2, 32'h0, rsp);
		axi_write(IDX_PWR, 32'h0100, rsp);
		settle();
		chk("pwr_dflt", card_power_out, 3'b011);
	endtask

	task automatic t_wp;
		logic p;
		for (int k = 0; k < 8; k++)
		begin
			p = k[2];
			if (k[1:0] == 2'b00)
			begin
				axi_write(IDX_ATT0, {25'h0, p, 6'h0}, rsp);
				axi_write(IDX_ATT1, {24'h0, !p, 7'h0}, rsp);
			end
			@(posedge aclk);
			write_protect_switch_in <= k[1:0];
			settle();
			chk("wp0", write_protect_out[0], !(p ^ k[0]));
			chk("wp1", write_protect_out[1], !(!p ^ k[1]));
		end
		chk("inq_off", inquiry_custom_out, 0);
		chk("ext_off", ext_cfg_enable_out, 0);
	endtask

	task automatic t_led;
		for (int v = 0; v < 16; v++)
		begin
			axi_write(IDX_ATT1, {26'h0, v[1], v[0], 4'h0}, rsp);
			@(posedge aclk);
			card_inserted <= v[2];
			media_access <= v[3];
			settle();
			chk("led", activity_led_out, (v[3] | (v[1] & v[2])) ^ v[0]);
			chk("attach_off", card_attach_out, 1);
		end
		axi_write(IDX_ATT2, 32'h1, rsp);
		for (int v = 0; v < 2; v++)
		begin
			@(posedge aclk);
			card_inserted <= v[0];
			settle();
			chk("attach_on", card_attach_out, v[0]);
		end
	endtask

	task automatic t_misc;
		axi_write(10'h040, 32'hff, rsp);
		chk("unmapped_w", rsp, RESP_SLVERR);
		rchk("unmapped_r", 10'h040, 32'h0, RESP_SLVERR);
		axi_write(IDX_PWR_RSVD, 32'hffff, rsp);
		chk("rsvd_w", rsp, RESP_OKAY);
		rchk("rsvd_r", IDX_PWR_RSVD, 32'h0, RESP_OKAY);
		// Reload picks up a changed store image
		image.att0 = 8'h90;
		axi_write(IDX_CTRL, 32'h1, rsp);
		repeat (2) @(negedge aclk);
		wait_loaded();
		rchk("reload", IDX_ATT0, 32'h90, RESP_OKAY);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		num_errors = 0;
		comparisons = 0;
		aresetn = 1'b0;
		s_awaddr = 12'h0;
		s_araddr = 12'h0;
		s_wdata = 32'h0;
		s_wstrb = 4'hf;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h0;
		write_protect_switch_in = 2'h0;
		card_inserted = 1'b0;
		media_access = 1'b0;
		image = {16'h085a, 8'hff, 8'hff, 8'hff, 8'hff, MAXPWR_LIMIT};
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_load();
		t_power();
		t_wp();
		t_led();
		t_misc();
		tally_and_finish();
	end

	initial
	begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
